// File: verilog/satc_core.sv
// Serial control front end of a two-channel stepped attenuator.
// Assumes the serial clock, load line and data arrive asynchronously and are far
// slower than clk (serial clock at most a few MHz against 50 MHz).
`timescale 1ns/1ps

module satc_core
  import satc_pkg::*;
#(
  parameter int WORD_BITS = SATC_WORD_BITS,  // Shift register length in bits
  parameter int CHANNELS  = SATC_CHANNELS    // Number of attenuation channels
)
(
  input  wire logic       clk,             // 50 MHz system clock
  input  wire logic       rst,             // Synchronous reset, active high
  input  wire logic       serial_clk,      // Serial clock pin
  input  wire logic       load_shift_n,    // Shift enable low, latch on rising edge
  input  wire logic       serial_din,      // Serial data in
  output logic            serial_dout,     // Serial data out to next device
  output logic [7:0]      channel_a_code,  // Channel A attenuation code
  output logic [7:0]      channel_b_code,  // Channel B attenuation code
  output logic            channel_a_mute,  // Channel A muted
  output logic            channel_b_mute,  // Channel B muted
  output logic [7:0]      channel_a_hdb,   // Channel A attenuation, half-dB units
  output logic [7:0]      channel_b_hdb,   // Channel B attenuation, half-dB units
  output logic            word_strobe      // One-cycle pulse when a word is decoded
);

  typedef logic [SATC_FIELD_BITS-1:0] satc_code_t;

  // The fixed ports carry two channels and a word of one address and one code byte
  if (WORD_BITS != 2 * SATC_FIELD_BITS) begin : g_bad_word
    $error("satc_core: WORD_BITS must be twice the field width");
  end
  if (CHANNELS != SATC_CHANNELS) begin : g_bad_chan
    $error("satc_core: CHANNELS must match the two channel ports");
  end

  // Mute covers the whole top of the code range
  function automatic logic satc_is_mute(input satc_code_t code);
    return code >= SATC_MUTE_MIN;
  endfunction

  // Attenuation in half-dB steps for a code; mute maps to a fixed marker
  function automatic satc_code_t satc_hdb(input satc_code_t code);
    satc_code_t steps;
    satc_code_t result;
    steps = 8'(code - SATC_COARSE_MIN);
    if (satc_is_mute(code)) begin
      result = SATC_MUTE_HDB;
    end else if (code <= SATC_FINE_MAX) begin
      result = code;
    end else begin
      result = 8'(SATC_COARSE_BASE_HDB + {steps[6:0], 1'b0});
    end
    return result;
  endfunction

  // Whole-byte compare, so an address such as 0x80 never aliases channel A
  function automatic logic satc_addr_hit(input satc_code_t addr, input int ch);
    return addr == 8'(ch);
  endfunction

  logic [2:0]              sclk_sync_r;
  logic [2:0]              load_sync_r;
  logic [1:0]              din_sync_r;
  logic [WORD_BITS-1:0]    shift_r;
  logic [WORD_BITS-1:0]    word_r;
  logic                    decode_r;
  satc_code_t              code_r [CHANNELS];
  logic                    mute_r [CHANNELS];
  satc_code_t              hdb_r  [CHANNELS];
  logic                    strobe_r;
  logic                    sclk_rise;
  logic                    load_rise;
  logic                    load_low;
  logic                    din_bit;
  logic                    shift_en;
  satc_code_t              word_addr;
  satc_code_t              word_code;

  // Two-stage synchronisers; the third stage only feeds edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_sync_r <= 3'h0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], serial_clk};
    end
  end

  // Reset to the idle high level, so no false latch edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      load_sync_r <= 3'h7;
    end else begin
      load_sync_r <= {load_sync_r[1:0], load_shift_n};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      din_sync_r <= 2'h0;
    end else begin
      din_sync_r <= {din_sync_r[0], serial_din};
    end
  end

  assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
  assign load_rise = load_sync_r[1] & ~load_sync_r[2];
  assign load_low  = ~load_sync_r[1];
  assign din_bit   = din_sync_r[1];
  assign shift_en  = sclk_rise & load_low;

  // Shift register, MSB first; serial clock edges with the load line high are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= SATC_SHIFT_RST;
    end else if (shift_en) begin
      shift_r <= {shift_r[WORD_BITS-2:0], din_bit};
    end
  end

  assign serial_dout = shift_r[WORD_BITS-1];

  // Copy of the word taken at the rising load edge; decoding works on the copy,
  // so a new frame that starts at once cannot disturb it
  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= SATC_SHIFT_RST;
    end else if (load_rise) begin
      word_r <= shift_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      decode_r <= 1'b0;
    end else begin
      decode_r <= load_rise;
    end
  end

  assign word_addr = word_r[WORD_BITS-1 -: SATC_FIELD_BITS];
  assign word_code = word_r[SATC_FIELD_BITS-1:0];

  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic hit;

      assign hit = decode_r && satc_addr_hit(word_addr, ch);

      // Raw code is kept as sent, mute codes included
      always_ff @(posedge clk) begin
        if (rst) begin
          code_r[ch] <= SATC_RESET_CODE;
        end else if (hit) begin
          code_r[ch] <= word_code;
        end
      end

      // Mute flag, set by reset and by any high code
      always_ff @(posedge clk) begin
        if (rst) begin
          mute_r[ch] <= 1'b1;
        end else if (hit) begin
          mute_r[ch] <= satc_is_mute(word_code);
        end
      end

      // Attenuation in half-dB units, updated with the code in the same cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          hdb_r[ch] <= SATC_MUTE_HDB;
        end else if (hit) begin
          hdb_r[ch] <= satc_hdb(word_code);
        end
      end
    end
  endgenerate

  // One pulse per latched word, whether or not its address matched
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= decode_r;
    end
  end

  assign word_strobe    = strobe_r;
  assign channel_a_code = code_r[0];
  assign channel_b_code = code_r[1];
  assign channel_a_mute = mute_r[0];
  assign channel_b_mute = mute_r[1];
  assign channel_a_hdb  = hdb_r[0];
  assign channel_b_hdb  = hdb_r[1];

endmodule

// File: inc/satc_pkg.sv
// Constants for the serial attenuator control block.
// Assumes one system clock; serial pins are asynchronous to it.
package satc_pkg;
  localparam int          SATC_WORD_BITS  = 16;
  localparam int          SATC_FIELD_BITS = 8;
  localparam int          SATC_CHANNELS   = 2;
  localparam logic [7:0]  SATC_ADDR_CH_A  = 8'h00;
  localparam logic [7:0]  SATC_ADDR_CH_B  = 8'h01;
  localparam logic [7:0]  SATC_MUTE_MIN   = 8'h7F;
  localparam logic [7:0]  SATC_FINE_MAX   = 8'h5F;
  localparam logic [7:0]  SATC_COARSE_MIN = 8'h60;
  localparam logic [7:0]  SATC_RESET_CODE = 8'h7F;
  localparam logic [15:0] SATC_SHIFT_RST  = 16'h0000;
  // Attenuation in half-dB units: fine range tops at 95, coarse adds 2 per count
  localparam logic [7:0]  SATC_COARSE_BASE_HDB = 8'h60;
  localparam logic [7:0]  SATC_MUTE_HDB        = 8'hC8;
endpackage

// File: tb/satc_core_asserts.sv
// Port checker for satc_core.
// Assumes it is bound to every satc_core instance.
`timescale 1ns/1ps
module satc_core_asserts(
  input wire logic       clk, rst, load_shift_n, serial_dout, word_strobe,
  input wire logic       channel_a_mute, channel_b_mute,
  input wire logic [7:0] channel_a_code, channel_b_code, channel_a_hdb
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pulse; word_strobe ##1 !word_strobe; endsequence
  a_reset_mute: assert property ($fell(rst) |-> channel_a_mute && channel_b_mute)
    else $error("channel live after reset");
  a_mute_a: assert property (channel_a_mute == (channel_a_code >= 8'h7F))
    else $error("channel a mute wrong");
  a_mute_b: assert property (channel_b_mute == (channel_b_code >= 8'h7F))
    else $error("channel b mute wrong");
  a_strobe_once: assert property (word_strobe |-> s_pulse)
    else $error("strobe longer than a cycle");
  a_code_strobe: assert property ($changed(channel_a_code) |-> word_strobe)
    else $error("code changed without latch");
  a_hdb_fine: assert property (channel_a_code <= 8'h5F |-> channel_a_hdb == channel_a_code)
    else $error("fine step wrong");
  a_dout_idle: assert property (load_shift_n [*5] |=> $stable(serial_dout))
    else $error("shift while disabled");
  a_chan_indep: assert property ($changed(channel_a_code) |-> $stable(channel_b_code))
    else $error("channels not independent");
endmodule
bind satc_core satc_core_asserts satc_core_asserts_i(.clk, .rst, .load_shift_n, .serial_dout,
  .word_strobe, .channel_a_mute, .channel_b_mute, .channel_a_code, .channel_b_code, .channel_a_hdb);

// File: tb/satc_host_model.sv
// Host model driving the three serial pins.
// Assumes clk is the bench clock; one bit takes 8 clk (160 ns).
`timescale 1ns/1ps
module satc_host_model(input wire logic clk, output logic serial_clk, load_shift_n, serial_din);
  initial {serial_clk, load_shift_n, serial_din} = 3'b010;
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [31:0] w);
    hold(1);
    load_shift_n = 0;
    for (int i = 31; i >= 0; i--) begin
      serial_din = w[i];
      hold(4);
      serial_clk = 1;
      hold(4);
      serial_clk = 0;
    end
    hold(4);
    load_shift_n = 1;
    serial_din = ~serial_din;
    hold(8);
  endtask
endmodule

// File: tb/test_satc_core.sv
// Self-checking bench for satc_core.
// Assumes the host model sends two chained words per frame.
`timescale 1ns/1ps
module test_satc_core;
  logic clk = 0, rst = 1, sclk, load_n, din, dout, a_mute, b_mute, stb;
  logic [7:0] a_code, b_code, a_hdb, b_hdb;
  int fails = 0, checks = 0, cyc = 0;
  always #10 clk = ~clk;
  satc_host_model satc_host_model_i(.clk, .serial_clk(sclk), .load_shift_n(load_n), .serial_din(din));
  satc_core satc_core_i(.clk, .rst, .serial_clk(sclk), .load_shift_n(load_n), .serial_din(din),
    .serial_dout(dout), .channel_a_code(a_code), .channel_b_code(b_code), .channel_a_mute(a_mute),
    .channel_b_mute(b_mute), .channel_a_hdb(a_hdb), .channel_b_hdb(b_hdb), .word_strobe(stb));
  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop;
    end
  end
  task automatic pulse_reset;
    rst = 1;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    pulse_reset;
    chk("a_hdb", 8'hC8, a_hdb);
    chk("a_mute", 8'h01, {7'h00, a_mute});
    satc_host_model_i.send(32'h0155_0005);
    chk("a_code", 8'h05, a_code);
    chk("a_hdb", 8'h05, a_hdb);
    chk("a_mute", 8'h00, {7'h00, a_mute});
    chk("b_code", 8'h7F, b_code);
    satc_host_model_i.send(32'h0000_0161);
    chk("dout", 8'h00, {7'h00, dout});
    chk("b_hdb", 8'h62, b_hdb);
    chk("a_code", 8'h05, a_code);
    satc_host_model_i.send(32'h0101_0203);
    chk("bad_a", 8'h05, a_code);
    satc_host_model_i.send(32'h0001_01FF);
    chk("b_mute", 8'h01, {7'h00, b_mute});
    chk("b_hdb", 8'hC8, b_hdb);
    chk("b_code", 8'hFF, b_code);
    satc_host_model_i.send(32'h0000_FF00);
    chk("dout", 8'h01, {7'h00, dout});
    chk("bad_b", 8'hFF, b_code);
    pulse_reset;
    chk("a_code", 8'h7F, a_code);
    chk("b_mute", 8'h01, {7'h00, b_mute});
    chk("dout", 8'h00, {7'h00, dout});
    report_and_stop;
  end
endmodule
